// *** design/vcmc_defs.vh ***
// Constants for the vocoder codec mode control block
`ifndef VCMC_DEFS_VH
`define VCMC_DEFS_VH
`define VCMC_ID_SETUP 8'h38
`define VCMC_ID_ENTRY 8'h2A
`define VCMC_ID_EXIT 8'h2B
`define VCMC_ID_CHANFMT 8'h15
`define VCMC_ID_SPCHFMT 8'h16
`define VCMC_MAX_REGS 4'hA
`define VCMC_ENTRY_SEL_BIT 2
`define VCMC_ENTRY_PASS_BIT 1
`define VCMC_ENTRY_SKEW_BIT 0
`define VCMC_CTRL_LO 1
`define VCMC_CNT_HI 5
`define VCMC_CNT_LO 4
`define VCMC_SP_CNT_HI 3
`define VCMC_SP_CNT_LO 2
`define VCMC_NOMINAL_SAMPLES 8'hA0
`define VCMC_FRAME_MS 20
`define VCMC_CLK_HZ 10000000
`define VCMC_FRAME_CYCLES (`VCMC_FRAME_MS * (`VCMC_CLK_HZ / 1000))
`define VCMC_I2C_DIV 50
`endif

// *** design/vcmc_i2c_writer.v ***
// I2C register write engine for the codec setup list
`timescale 1ns/10ps
`include "vcmc_defs.vh"
module vcmc_i2c_writer #(
    parameter DIV = `VCMC_I2C_DIV,
    parameter [6:0] DEV_ADDR = 7'h1A
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Request
    input wire start_i,
    input wire [7:0] reg_i,
    input wire [7:0] data_i,
    output wire busy_o,
    output reg done_o,
    // I2C pins
    input wire scl_i,
    output wire scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_START = 4'b0010;
    localparam ST_BITS = 4'b0100;
    localparam ST_STOP = 4'b1000;

    reg [3:0] state;
    reg [15:0] div_cnt;
    reg [1:0] phase;
    reg [4:0] bit_idx;
    reg [26:0] shreg;
    wire tick;

    assign tick = (div_cnt == DIV[15:0] - 16'h0001);
    assign busy_o = (state != ST_IDLE);
    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Three bytes with an ack slot after each (slave ack not checked)
    always @(posedge core_clk_i) begin
        done_o <= 1'b0;
        if (!rst_n_i) begin
            state <= ST_IDLE;
            div_cnt <= 16'h0000;
            phase <= 2'h0;
            bit_idx <= 5'h00;
            shreg <= 27'h0000000;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            div_cnt <= (tick || state == ST_IDLE) ? 16'h0000 : div_cnt + 16'h0001;
            case (state)
                ST_IDLE: begin
                    scl_oe_o <= 1'b0;
                    sda_oe_o <= 1'b0;
                    if (start_i) begin
                        shreg <= {DEV_ADDR, 1'b0, 1'b1, reg_i, 1'b1, data_i, 1'b1};
                        state <= ST_START;
                        phase <= 2'h0;
                    end
                end
                ST_START: if (tick) begin
                    sda_oe_o <= 1'b1;
                    phase <= phase + 2'h1;
                    if (phase == 2'h1) begin
                        scl_oe_o <= 1'b1;
                        bit_idx <= 5'h00;
                        phase <= 2'h0;
                        state <= ST_BITS;
                    end
                end
                ST_BITS: if (tick) begin
                    phase <= phase + 2'h1;
                    case (phase)
                        2'h0: sda_oe_o <= ~shreg[26];
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: scl_oe_o <= 1'b0;
                        default: begin
                            scl_oe_o <= 1'b1;
                            shreg <= {shreg[25:0], 1'b1};
                            if (bit_idx == 5'h1A) begin
                                state <= ST_STOP;
                                phase <= 2'h0;
                            end else begin
                                bit_idx <= bit_idx + 5'h01;
                            end
                        end
                    endcase
                end
                ST_STOP: if (tick) begin
                    phase <= phase + 2'h1;
                    // Data pulled low a tick after clock, never on the same edge
                    if (phase == 2'h0) begin
                        sda_oe_o <= 1'b1;
                    end else if (phase == 2'h1) begin
                        scl_oe_o <= 1'b0;
                    end else begin
                        sda_oe_o <= 1'b0;
                        state <= ST_IDLE;
                        done_o <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** design/vcmc_top.v ***
// Codec mode command interpreter: field parsing, mode control and responses
`timescale 1ns/10ps
`include "vcmc_defs.vh"
module vcmc_top #(
    parameter FRAME_CYCLES = `VCMC_FRAME_CYCLES,
    parameter MAX_REGS = 10
) (
    // Clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // Command field byte stream from host
    input wire cmd_valid_i,
    input wire cmd_first_i,
    input wire [7:0] cmd_data_i,
    output wire cmd_ready_o,
    // Response byte stream to host
    output reg rsp_valid_o,
    output reg rsp_last_o,
    output reg [7:0] rsp_data_o,
    input wire rsp_ready_i,
    // Codec control
    output reg codec_reset_o,
    output reg codec_mode_o,
    output reg sample_sel_o,
    output reg pass_thru_o,
    output reg skew_ctrl_o,
    // Channel packet trigger for the encoder path
    output reg chan_pkt_o,
    output reg [15:0] chan_fmt_o,
    output reg [15:0] spch_fmt_o,
    // Per-frame inclusion decisions
    input wire frame_i,
    input wire [7:0] frame_samples_i,
    input wire ctrl_changed_i,
    input wire spch_frame_i,
    input wire [7:0] spch_samples_i,
    input wire dec_changed_i,
    output reg chan_incl_ctrl_o,
    output reg chan_incl_cnt_o,
    output reg spch_incl_ctrl_o,
    output reg spch_incl_cnt_o,
    // I2C pins
    input wire scl_i,
    output wire scl_o,
    output wire scl_oe_o,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o
);
    localparam P_IDLE = 6'b000001;
    localparam P_SETUP_N = 6'b000010;
    localparam P_SETUP_D = 6'b000100;
    localparam P_ENTRY = 6'b001000;
    localparam P_FMT_HI = 6'b010000;
    localparam P_FMT_LO = 6'b100000;

    localparam A_IDLE = 4'b0001;
    localparam A_WRITE = 4'b0010;
    localparam A_WAIT = 4'b0100;
    localparam A_RSP = 4'b1000;

    reg [5:0] pstate;
    reg [3:0] astate;
    reg [7:0] regs [0:2*MAX_REGS-1];
    reg [4:0] wr_idx;
    reg [3:0] reg_count;
    reg [3:0] send_idx;
    reg [7:0] fmt_id;
    reg [7:0] fmt_hi;
    reg [31:0] frame_cnt;
    reg [7:0] last_chan_cnt;
    reg [7:0] last_spch_cnt;
    reg wr_start;
    // Pending response: id, whether a data byte follows
    reg rsp_pend;
    reg [7:0] rsp_id;
    reg rsp_has_data;
    reg rsp_second;
    wire wr_busy;
    wire wr_done;
    integer i;

    // Count inclusion code: never, always, changed, not nominal
    function cnt_incl;
        input [1:0] code;
        input [7:0] cur;
        input [7:0] last;
        begin
            case (code)
                2'b00: cnt_incl = 1'b0;
                2'b01: cnt_incl = 1'b1;
                2'b10: cnt_incl = (cur != last);
                default: cnt_incl = (cur != `VCMC_NOMINAL_SAMPLES);
            endcase
        end
    endfunction

    // Control word inclusion code; reserved 11 treated as never
    function ctrl_incl;
        input [1:0] code;
        input changed;
        begin
            case (code)
                2'b01: ctrl_incl = 1'b1;
                2'b10: ctrl_incl = changed;
                default: ctrl_incl = 1'b0;
            endcase
        end
    endfunction

    // Stall commands while a response is waiting or codec setup runs
    assign cmd_ready_o = !rsp_pend && (astate == A_IDLE);

    // --------------------------------------------------------------
    // Field parser
    // --------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pstate <= P_IDLE;
            wr_idx <= 5'h00;
            reg_count <= 4'h0;
            fmt_id <= 8'h00;
            fmt_hi <= 8'h00;
            chan_fmt_o <= 16'h0000;
            spch_fmt_o <= 16'h0000;
            for (i = 0; i < 2*MAX_REGS; i = i + 1) begin
                regs[i] <= 8'h00;
            end
        end else if (cmd_valid_i && cmd_ready_o) begin
            if (cmd_first_i) begin
                pstate <= P_IDLE;
            end
            case (cmd_first_i ? P_IDLE : pstate)
                P_IDLE: begin
                    if (cmd_data_i == `VCMC_ID_SETUP) begin
                        pstate <= P_SETUP_N;
                    end else if (cmd_data_i == `VCMC_ID_ENTRY) begin
                        pstate <= P_ENTRY;
                    end else if (cmd_data_i == `VCMC_ID_CHANFMT ||
                                 cmd_data_i == `VCMC_ID_SPCHFMT) begin
                        fmt_id <= cmd_data_i;
                        pstate <= P_FMT_HI;
                    end
                end
                P_SETUP_N: begin
                    // Count above ten is clipped to the storage depth
                    reg_count <= (cmd_data_i[7:4] != 4'h0 ||
                                  cmd_data_i[3:0] > `VCMC_MAX_REGS) ?
                                 `VCMC_MAX_REGS : cmd_data_i[3:0];
                    wr_idx <= 5'h00;
                    pstate <= (cmd_data_i == 8'h00) ? P_IDLE : P_SETUP_D;
                end
                P_SETUP_D: begin
                    regs[wr_idx] <= cmd_data_i;
                    wr_idx <= wr_idx + 5'h01;
                    if (wr_idx == {reg_count, 1'b0} - 5'h01) begin
                        pstate <= P_IDLE;
                    end
                end
                P_ENTRY: pstate <= P_IDLE;
                P_FMT_HI: begin
                    fmt_hi <= cmd_data_i;
                    pstate <= P_FMT_LO;
                end
                P_FMT_LO: begin
                    if (fmt_id == `VCMC_ID_CHANFMT) begin
                        chan_fmt_o <= {fmt_hi, cmd_data_i};
                    end else begin
                        spch_fmt_o <= {fmt_hi, cmd_data_i};
                    end
                    pstate <= P_IDLE;
                end
                default: pstate <= P_IDLE;
            endcase
        end
    end

    wire take;
    wire entry_byte;
    wire exit_cmd;
    wire setup_end;
    wire fmt_end;
    assign take = cmd_valid_i && cmd_ready_o;
    assign entry_byte = take && !cmd_first_i && pstate == P_ENTRY;
    assign exit_cmd = take && (cmd_first_i || pstate == P_IDLE) &&
                      cmd_data_i == `VCMC_ID_EXIT;
    assign setup_end = take && !cmd_first_i &&
                       ((pstate == P_SETUP_N && cmd_data_i == 8'h00) ||
                        (pstate == P_SETUP_D && wr_idx == {reg_count, 1'b0} - 5'h01));
    assign fmt_end = take && !cmd_first_i && pstate == P_FMT_LO;

    // --------------------------------------------------------------
    // Codec mode control and setup delivery
    // --------------------------------------------------------------
    always @(posedge core_clk_i) begin
        wr_start <= 1'b0;
        if (!rst_n_i) begin
            astate <= A_IDLE;
            codec_reset_o <= 1'b0;
            codec_mode_o <= 1'b0;
            sample_sel_o <= 1'b0;
            pass_thru_o <= 1'b0;
            skew_ctrl_o <= 1'b0;
            send_idx <= 4'h0;
        end else begin
            if (exit_cmd) begin
                codec_mode_o <= 1'b0;
                codec_reset_o <= 1'b0;
            end
            case (astate)
                A_IDLE: if (entry_byte) begin
                    codec_reset_o <= 1'b1;
                    sample_sel_o <= cmd_data_i[`VCMC_ENTRY_SEL_BIT];
                    pass_thru_o <= cmd_data_i[`VCMC_ENTRY_PASS_BIT];
                    skew_ctrl_o <= cmd_data_i[`VCMC_ENTRY_SKEW_BIT];
                    send_idx <= 4'h0;
                    astate <= A_WRITE;
                end
                A_WRITE: begin
                    if (send_idx == reg_count) begin
                        astate <= A_RSP;
                    end else begin
                        wr_start <= 1'b1;
                        astate <= A_WAIT;
                    end
                end
                A_WAIT: if (wr_done) begin
                    send_idx <= send_idx + 4'h1;
                    astate <= A_WRITE;
                end
                A_RSP: begin
                    // Channel packets start once setup is through
                    codec_mode_o <= 1'b1;
                    astate <= A_IDLE;
                end
                default: astate <= A_IDLE;
            endcase
        end
    end

    vcmc_i2c_writer u_i2c (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(wr_start),
        .reg_i(regs[{send_idx, 1'b0}]),
        .data_i(regs[{send_idx, 1'b1}]),
        .busy_o(wr_busy),
        .done_o(wr_done),
        .scl_i(scl_i),
        .scl_o(scl_o),
        .scl_oe_o(scl_oe_o),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o)
    );

    // --------------------------------------------------------------
    // Response generation
    // --------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rsp_pend <= 1'b0;
            rsp_id <= 8'h00;
            rsp_has_data <= 1'b0;
            rsp_second <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_last_o <= 1'b0;
            rsp_data_o <= 8'h00;
        end else if (rsp_pend) begin
            if (!rsp_valid_o || rsp_ready_i) begin
                if (rsp_valid_o && rsp_last_o) begin
                    rsp_pend <= 1'b0;
                    rsp_valid_o <= 1'b0;
                    rsp_last_o <= 1'b0;
                end else if (rsp_valid_o) begin
                    rsp_data_o <= 8'h00;
                    rsp_last_o <= 1'b1;
                    rsp_second <= 1'b1;
                end else begin
                    rsp_valid_o <= 1'b1;
                    rsp_data_o <= rsp_id;
                    rsp_last_o <= !rsp_has_data;
                    rsp_second <= 1'b0;
                end
            end
        end else begin
            if (astate == A_RSP) begin
                rsp_pend <= 1'b1;
                rsp_id <= `VCMC_ID_ENTRY;
                rsp_has_data <= 1'b0;
            end else if (setup_end) begin
                rsp_pend <= 1'b1;
                rsp_id <= `VCMC_ID_SETUP;
                rsp_has_data <= 1'b0;
            end else if (exit_cmd) begin
                rsp_pend <= 1'b1;
                rsp_id <= `VCMC_ID_EXIT;
                rsp_has_data <= 1'b0;
            end else if (fmt_end) begin
                rsp_pend <= 1'b1;
                rsp_id <= fmt_id;
                rsp_has_data <= (fmt_id == `VCMC_ID_CHANFMT);
            end
        end
    end

    // --------------------------------------------------------------
    // Frame timer and inclusion decisions
    // --------------------------------------------------------------
    always @(posedge core_clk_i) begin
        chan_pkt_o <= 1'b0;
        if (!rst_n_i) begin
            frame_cnt <= 32'h00000000;
            last_chan_cnt <= `VCMC_NOMINAL_SAMPLES;
            last_spch_cnt <= `VCMC_NOMINAL_SAMPLES;
            chan_incl_ctrl_o <= 1'b0;
            chan_incl_cnt_o <= 1'b0;
            spch_incl_ctrl_o <= 1'b0;
            spch_incl_cnt_o <= 1'b0;
        end else begin
            if (!codec_mode_o || exit_cmd) begin
                frame_cnt <= 32'h00000000;
            end else if (frame_cnt == FRAME_CYCLES - 1) begin
                frame_cnt <= 32'h00000000;
                chan_pkt_o <= 1'b1;
            end else begin
                frame_cnt <= frame_cnt + 32'h00000001;
            end
            if (frame_i) begin
                chan_incl_ctrl_o <= ctrl_incl(chan_fmt_o[`VCMC_CTRL_LO:0],
                                              ctrl_changed_i);
                chan_incl_cnt_o <= cnt_incl(chan_fmt_o[`VCMC_CNT_HI:`VCMC_CNT_LO],
                                            frame_samples_i, last_chan_cnt);
                last_chan_cnt <= frame_samples_i;
            end
            if (spch_frame_i) begin
                spch_incl_ctrl_o <= ctrl_incl(spch_fmt_o[`VCMC_CTRL_LO:0],
                                              dec_changed_i);
                spch_incl_cnt_o <= cnt_incl(spch_fmt_o[`VCMC_SP_CNT_HI:`VCMC_SP_CNT_LO],
                                            spch_samples_i, last_spch_cnt);
                last_spch_cnt <= spch_samples_i;
            end
        end
    end
endmodule

// *** verif/vcmc_checker_asserts.sv ***
// Port-level assertions for the codec mode control block
`timescale 1ns/10ps
module vcmc_checker #(
    parameter FRAME_CYCLES = 50
) (
    // Clock, reset and host side
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cmd_valid_i,
    input wire cmd_first_i,
    input wire [7:0] cmd_data_i,
    input wire cmd_ready_o,
    input wire rsp_valid_o,
    input wire rsp_last_o,
    input wire [7:0] rsp_data_o,
    input wire rsp_ready_i,
    // Codec side
    input wire codec_reset_o,
    input wire codec_mode_o,
    input wire sample_sel_o,
    input wire pass_thru_o,
    input wire skew_ctrl_o,
    input wire chan_pkt_o,
    input wire [15:0] chan_fmt_o,
    input wire frame_i,
    input wire ctrl_changed_i,
    input wire chan_incl_ctrl_o,
    input wire scl_oe_o,
    input wire sda_oe_o
);
    wire taken = cmd_valid_i && cmd_ready_o;
    reg [7:0] last_id;
    reg [7:0] ent;
    reg [31:0] gap;
    reg seen;
    // Gap is only judged once a first packet has set the phase
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            last_id <= 8'h00;
            ent <= 8'h00;
            gap <= 32'h00000000;
            seen <= 1'b0;
        end else begin
            if (taken && cmd_first_i)
                last_id <= cmd_data_i;
            if (taken && !cmd_first_i && last_id == 8'h2A)
                ent <= cmd_data_i;
            gap <= chan_pkt_o ? 32'h00000001 : gap + 32'h00000001;
            seen <= codec_mode_o && (seen || chan_pkt_o);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence exit_taken;
        taken && cmd_first_i && cmd_data_i == 8'h2B;
    endsequence
    sequence fmt_head;
        rsp_valid_o && rsp_ready_i && !rsp_last_o && rsp_data_o == 8'h15;
    endsequence
    sequence fmt_tail;
        rsp_valid_o && rsp_last_o && rsp_data_o == 8'h00;
    endsequence
    chk_exit_drops_mode: assert property (exit_taken |=> !codec_reset_o && !codec_mode_o)
        else $error("mode or codec reset still high after exit");
    chk_fmt_rsp_pair: assert property (fmt_head |=> ##[0:3] fmt_tail)
        else $error("format reply lacks zero data byte");
    chk_rsp_multi_id: assert property (rsp_valid_o && !rsp_last_o |-> rsp_data_o == 8'h15)
        else $error("multi byte reply with wrong id");
    chk_rsp_hold_stall: assert property (rsp_valid_o && !rsp_ready_i |=>
        rsp_valid_o && $stable(rsp_data_o) && $stable(rsp_last_o))
        else $error("reply byte changed while stalled");
    chk_mode_has_reset: assert property (codec_mode_o |-> codec_reset_o)
        else $error("codec mode without codec reset set");
    chk_i2c_after_reset: assert property (scl_oe_o || sda_oe_o |-> codec_reset_o && !codec_mode_o)
        else $error("setup bus active outside setup phase");
    chk_entry_bits: assert property ($rose(codec_mode_o) |->
        {sample_sel_o, pass_thru_o, skew_ctrl_o} == ent[2:0])
        else $error("entry option bits not applied");
    chk_pkt_in_mode: assert property (chan_pkt_o |-> codec_mode_o)
        else $error("channel packet outside codec mode");
    chk_pkt_period: assert property (chan_pkt_o && seen |-> gap == FRAME_CYCLES)
        else $error("channel packet period wrong");
    chk_pkt_late: assert property (seen && codec_mode_o |-> gap <= FRAME_CYCLES)
        else $error("channel packet overdue");
    chk_incl_ctrl: assert property (frame_i |=> chan_incl_ctrl_o ==
        ($past(chan_fmt_o[1:0]) == 2'h1 || ($past(chan_fmt_o[1:0]) == 2'h2 &&
        $past(ctrl_changed_i))))
        else $error("encoder word inclusion wrong");
endmodule
bind vcmc_top vcmc_checker #(.FRAME_CYCLES(FRAME_CYCLES)) u_chk (.core_clk_i, .rst_n_i,
    .cmd_valid_i, .cmd_first_i, .cmd_data_i, .cmd_ready_o, .rsp_valid_o, .rsp_last_o,
    .rsp_data_o, .rsp_ready_i, .codec_reset_o, .codec_mode_o, .sample_sel_o, .pass_thru_o,
    .skew_ctrl_o, .chan_pkt_o, .chan_fmt_o, .frame_i, .ctrl_changed_i, .chan_incl_ctrl_o,
    .scl_oe_o, .sda_oe_o);

// *** verif/vcmc_codec_model.sv ***
// Codec end of the setup bus: pull-ups and write counting
`timescale 1ns/10ps
module vcmc_codec_model (
    // Open-drain enables from the block
    input wire scl_oe_i,
    input wire sda_oe_i,
    // Resolved levels and write count
    output wire scl_o,
    output wire sda_o,
    output integer starts_o
);
    // Released lines float high through the pull-ups
    assign scl_o = !scl_oe_i;
    assign sda_o = !sda_oe_i;
    initial starts_o = 0;
    // One start condition opens each register write
    always @(negedge sda_o)
        if (scl_o)
            starts_o = starts_o + 1;
endmodule

// *** verif/tb_vcmc_top.sv ***
// Self-checking bench for the codec mode control block
`timescale 1ns/10ps
module tb_vcmc_top;
    localparam F = 50;
    reg core_clk_i, rst_n_i, cmd_valid_i, cmd_first_i, frame_i, ctrl_changed_i;
    reg spch_frame_i, dec_changed_i;
    reg rsp_ready_i = 1'b0;
    reg [7:0] cmd_data_i, frame_samples_i, spch_samples_i, last_cs, last_ss;
    wire cmd_ready_o, rsp_valid_o, rsp_last_o, codec_reset_o, codec_mode_o, sample_sel_o;
    wire pass_thru_o, skew_ctrl_o, chan_pkt_o, scl, sda, scl_o, sda_o, scl_oe_o, sda_oe_o;
    wire chan_incl_ctrl_o, chan_incl_cnt_o, spch_incl_ctrl_o, spch_incl_cnt_o;
    wire [7:0] rsp_data_o;
    wire [15:0] chan_fmt_o, spch_fmt_o;
    reg [15:0] cf, sf;
    reg [8:0] rq[$];
    integer seed, failures, samples_checked, cycles, starts, i, v, k, n, s0, pk, r, rr;
    vcmc_top #(.FRAME_CYCLES(F)) i_dut (.core_clk_i, .rst_n_i, .cmd_valid_i, .cmd_first_i,
        .cmd_data_i, .cmd_ready_o, .rsp_valid_o, .rsp_last_o, .rsp_data_o, .rsp_ready_i,
        .codec_reset_o, .codec_mode_o, .sample_sel_o, .pass_thru_o, .skew_ctrl_o,
        .chan_pkt_o, .chan_fmt_o, .spch_fmt_o, .frame_i, .frame_samples_i, .ctrl_changed_i,
        .spch_frame_i, .spch_samples_i, .dec_changed_i, .chan_incl_ctrl_o, .chan_incl_cnt_o,
        .spch_incl_ctrl_o, .spch_incl_cnt_o, .scl_i(scl), .scl_o, .scl_oe_o, .sda_i(sda),
        .sda_o, .sda_oe_o);
    vcmc_codec_model i_codec (.scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o), .scl_o(scl),
        .sda_o(sda), .starts_o(starts));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // Host stalls replies at random
    always @(posedge core_clk_i) begin
        rr = $random(seed);
        rsp_ready_i <= rr[0];
        if (rsp_valid_o && rsp_ready_i)
            rq.push_back({rsp_last_o, rsp_data_o});
        cycles = cycles + 1;
        if (cycles == 100000) begin
            failures = failures + 1;
            stop_test;
        end
    end
    function inc_ctl(input [1:0] code, input chg);
        inc_ctl = code == 2'h1 || (code == 2'h2 && chg);
    endfunction
    function inc_cnt(input [1:0] code, input [7:0] cur, input [7:0] last);
        inc_cnt = code == 2'h1 || (code == 2'h2 && cur != last) || (code == 2'h3 && cur != 8'hA0);
    endfunction
    task check(input [15:0] got, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task send(input f, input [7:0] d);
        begin
            cmd_valid_i <= 1'b1;
            cmd_first_i <= f;
            cmd_data_i <= d;
            @(negedge core_clk_i);
            while (cmd_ready_o !== 1'b1)
                @(negedge core_clk_i);
            @(posedge core_clk_i);
        end
    endtask
    task idle;
        begin
            cmd_valid_i <= 1'b0;
            @(posedge core_clk_i);
        end
    endtask
    task expect_rsp(input [8:0] e);
        begin
            while (rq.size() == 0)
                @(posedge core_clk_i);
            check(16'(rq.pop_front()), 16'(e));
        end
    endtask
    // Corners: nominal count, repeat of last count, random count
    task frame(input [31:0] x);
        reg [7:0] cs, ss;
        begin
            cs = x[1:0] == 2'h0 ? 8'hA0 : (x[1:0] == 2'h1 ? last_cs : x[15:8]);
            ss = x[3:2] == 2'h0 ? 8'hA0 : (x[3:2] == 2'h1 ? last_ss : x[23:16]);
            frame_i <= 1'b1;
            frame_samples_i <= cs;
            ctrl_changed_i <= x[4];
            spch_frame_i <= 1'b1;
            spch_samples_i <= ss;
            dec_changed_i <= x[5];
            @(posedge core_clk_i);
            frame_i <= 1'b0;
            spch_frame_i <= 1'b0;
            @(negedge core_clk_i);
            check(16'(chan_incl_ctrl_o), 16'(inc_ctl(cf[1:0], x[4])));
            check(16'(chan_incl_cnt_o), 16'(inc_cnt(cf[5:4], cs, last_cs)));
            check(16'(spch_incl_ctrl_o), 16'(inc_ctl(sf[1:0], x[5])));
            check(16'(spch_incl_cnt_o), 16'(inc_cnt(sf[3:2], ss, last_ss)));
            last_cs = cs;
            last_ss = ss;
            @(posedge core_clk_i);
        end
    endtask
    task count_pkts;
        begin
            pk = 0;
            repeat (2 * F) begin
                @(posedge core_clk_i);
                if (chan_pkt_o === 1'b1)
                    pk = pk + 1;
            end
        end
    endtask
    task stop_test;
        begin
            $display("failures %0d samples_checked %0d", failures, samples_checked);
            if (failures == 0 && samples_checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        seed = 32'h639A;
        failures = 0;
        samples_checked = 0;
        cycles = 0;
        {rst_n_i, cmd_valid_i, cmd_first_i, frame_i, ctrl_changed_i} = 5'h00;
        {spch_frame_i, dec_changed_i, cf, sf} = 34'h0;
        {cmd_data_i, frame_samples_i, spch_samples_i} = 24'h000000;
        repeat (20) @(posedge core_clk_i);
        check(16'({codec_reset_o, codec_mode_o, chan_pkt_o, rsp_valid_o}), 16'h0000);
        check(chan_fmt_o | spch_fmt_o, 16'h0000);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        frame(32'h0);
        // Unknown id must leave no reply behind
        send(1'b1, 8'h77);
        for (i = 0; i < 16; i = i + 1) begin
            cf = {10'h000, i[3:2], 2'h0, i[1:0]};
            sf = {12'h000, i[3:2], i[1:0]};
            send(1'b1, 8'h15);
            send(1'b0, cf[15:8]);
            send(1'b0, cf[7:0]);
            send(1'b1, 8'h16);
            send(1'b0, sf[15:8]);
            send(1'b0, sf[7:0]);
            idle;
            expect_rsp({1'b0, 8'h15});
            expect_rsp({1'b1, 8'h00});
            expect_rsp({1'b1, 8'h16});
            check(chan_fmt_o, cf);
            check(spch_fmt_o, sf);
            repeat (3) frame($random(seed));
        end
        for (v = 0; v < 8; v = v + 1) begin
            n = v == 7 ? 10 : (v == 3 ? 1 : 0);
            send(1'b1, 8'h38);
            send(1'b0, n[7:0]);
            for (k = 0; k < n; k = k + 1) begin
                r = $random(seed);
                send(1'b0, r[7:0]);
                send(1'b0, r[15:8]);
            end
            idle;
            expect_rsp({1'b1, 8'h38});
            s0 = starts;
            send(1'b1, 8'h2A);
            send(1'b0, v[7:0]);
            idle;
            expect_rsp({1'b1, 8'h2A});
            check(16'({codec_reset_o, codec_mode_o, scl_o, sda_o}), 16'h000C);
            check(16'({sample_sel_o, pass_thru_o, skew_ctrl_o}), 16'(v[2:0]));
            check(16'(starts - s0), 16'(n));
            count_pkts;
            check(16'(pk), 16'h0002);
            send(1'b1, 8'h2B);
            idle;
            expect_rsp({1'b1, 8'h2B});
            check(16'({codec_reset_o, codec_mode_o}), 16'h0000);
            count_pkts;
            check(16'(pk), 16'h0000);
        end
        check(16'(rq.size()), 16'h0000);
        stop_test;
    end
endmodule
